/* hw/hamf_cfg.svh */
// Constants for the HDLC mode and address filter block
`ifndef HAMF_CFG_SVH
`define HAMF_CFG_SVH

// Protocol engine codes
`define HAMF_ENG_HDLC      2'b00
`define HAMF_ENG_BISYNC    2'b10
`define HAMF_ENG_ASYNC     2'b11

// HDLC submode codes
`define HAMF_SUB_AUTO      2'b00
`define HAMF_SUB_NONAUTO   2'b01
`define HAMF_SUB_ADDRMODE  2'b10
`define HAMF_SUB_TRANSP    2'b11

// PPP variant codes
`define HAMF_PPP_OFF       2'b00
`define HAMF_PPP_OCTET     2'b01
`define HAMF_PPP_ASYNC     2'b10
`define HAMF_PPP_BITSYNC   2'b11

// Fixed group addresses and command/response bit position
`define HAMF_GROUP_FE      8'hfe
`define HAMF_GROUP_FC      8'hfc
`define HAMF_CR_BIT        1

// PPP escape octet and its unmapping pattern
`define HAMF_PPP_ESC       8'h7d
`define HAMF_PPP_XOR       8'h20

// Least abort run lengths and async character size
`define HAMF_ABORT_HDLC    4'h7
`define HAMF_ABORT_PPP     4'hf
`define HAMF_CHAR_BITS     4'ha

// Status byte fields: route and command flags
`define HAMF_STAT_AUTO     1
`define HAMF_STAT_CMD      0

// Receive FIFO shape
`define HAMF_FIFO_DEPTH    16
`define HAMF_FIFO_WIDTH    9

`endif

/* hw/hamf_fifo.sv */
// Receive FIFO with valid/ready on both sides
module hamf_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input  wire logic             SYS_CLK,
  input  wire logic             RSTN,
  input  wire logic [WIDTH-1:0] IN_DATA,
  input  wire logic             IN_VALID,
  output logic                  IN_READY,
  output logic      [WIDTH-1:0] OUT_DATA,
  output logic                  OUT_VALID,
  input  wire logic             OUT_READY
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic [AW-1:0]    nxt_wr_ptr;
  logic [AW-1:0]    nxt_rd_ptr;
  logic [AW:0]      nxt_count;
  logic             push;
  logic             pop;

  // Honest full and empty flags
  assign IN_READY  = (count_ff != DEPTH[AW:0]);
  assign OUT_VALID = (count_ff != '0);
  assign OUT_DATA  = mem_ff[rd_ptr_ff];
  assign push      = IN_VALID & IN_READY;
  assign pop       = OUT_VALID & OUT_READY;

  // Pointer and count next values
  always_comb begin
    nxt_wr_ptr = wr_ptr_ff;
    nxt_rd_ptr = rd_ptr_ff;
    nxt_count  = count_ff;
    if (push) begin
      nxt_wr_ptr = (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
    end
    if (pop) begin
      nxt_rd_ptr = (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
    end
    case ({push, pop})
      2'b10:   nxt_count = count_ff + 1'b1;
      2'b01:   nxt_count = count_ff - 1'b1;
      default: nxt_count = count_ff;
    endcase
  end

  // Pointer registers
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      count_ff  <= nxt_count;
    end
  end

  // Storage, written only on a push
  always_ff @(posedge SYS_CLK) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= IN_DATA;
    end
  end
endmodule

/* hw/hamf_filter.sv */
// HDLC mode select and receive address filter toward the receive FIFO
// How it works
// - Engine code picks HDLC, ASYNC or BISYNC
// - Submode code picks auto, non-auto, address, transparent
// - Width bit: 16/8 bit, or address mode 1/0
// - PPP variant code; PPP needs width bit clear
// - High byte compared with FE, FC, two values
// - Control bit excludes high byte bit 1
// - Low byte compared; both bytes must pair
// - Only first high/low pair runs auto rules
// - Unmatched address frames silently discarded
// - One-byte address: first command, second response
// - Compare bits maskable for broadcast acceptance
// - Auto mode: window one, control, data, status
// - Non-auto: valid frames all stored, no window
// - Address mode 1: high byte only, dropped
// - Address mode 0: every frame stored whole
// - Extended transparent is a bit-transparent HDLC submode
// - Async PPP frames become mapped async characters
// - Bit sync PPP: mode 0, abort 15 ones
// - Octet PPP: no stuffing, mapping, unmapping
// - Async PPP characters: start, 8 data, stop
`include "hamf_cfg.svh"

module hamf_filter
  import hamf_pkg::*;
#(
  parameter int FIFO_DEPTH = `HAMF_FIFO_DEPTH
) (
  input  wire logic       SYS_CLK,
  input  wire logic       RSTN,
  input  wire logic [1:0] ENGINE_SELECT,
  input  wire logic [1:0] HDLC_SUBMODE_SELECT,
  input  wire logic       ADDRESS_WIDTH_SELECT,
  input  wire logic [1:0] PPP_VARIANT_SELECT,
  input  wire logic [7:0] HIGH_ADDR_COMPARE_A,
  input  wire logic [7:0] HIGH_ADDR_COMPARE_B,
  input  wire logic [7:0] LOW_ADDR_COMPARE_A,
  input  wire logic [7:0] LOW_ADDR_COMPARE_B,
  input  wire logic       CMD_RESP_HANDLING_BIT,
  input  wire logic [7:0] HIGH_ADDR_MASK,
  input  wire logic [7:0] LOW_ADDR_MASK,
  input  wire logic [7:0] RX_DATA,
  input  wire logic       RX_VALID,
  input  wire logic       RX_LAST,
  input  wire logic [5:0] RX_STATUS,
  output logic            RX_READY,
  output logic      [7:0] RFIFO_DATA,
  output logic            RFIFO_IS_STATUS,
  output logic            RFIFO_VALID,
  input  wire logic       RFIFO_READY,
  output logic            ENGINE_HDLC,
  output logic            ENGINE_ASYNC,
  output logic            ENGINE_BISYNC,
  output logic            MODE_TRANSPARENT,
  output logic            STUFFING_ON,
  output logic            CHAR_MAP_ON,
  output logic            ASYNC_CHAR_ON,
  output logic      [3:0] ASYNC_CHAR_BITS,
  output logic      [3:0] ABORT_MIN_ONES,
  output logic            CONFIG_ERROR
);
  localparam int W = `HAMF_FIFO_WIDTH;

  hamf_state_type state_ff;
  hamf_state_type nxt_state;
  logic           hi_a_ff, hi_a;
  logic           hi_any_ff, hi_any;
  logic           auto_ff, nxt_auto;
  logic           cmd_ff, nxt_cmd;
  logic           vr_ff, nxt_vr;
  logic           esc_ff, nxt_esc;
  logic           pend_ff, nxt_pend;
  logic     [7:0] pend_stat_ff, nxt_pend_stat;
  logic           mode_ff [8];
  logic           nxt_mode [8];
  logic     [3:0] abort_ff, nxt_abort;

  logic           is_hdlc, ppp_on, unmap_on, mode0_like;
  logic           beat, byte_ok;
  logic     [7:0] rx_byte;
  logic     [7:0] cr_mask;
  logic           lo_a, lo_b;
  logic           wr_now;
  logic     [W-1:0] fifo_in;
  logic           fifo_in_ready;
  logic     [W-1:0] fifo_out;

  // Masked compare: mask bit set means that bit is ignored
  function automatic logic addr_hit(input logic [7:0] rx, input logic [7:0] ref_v,
                                    input logic [7:0] ignore);
    addr_hit = (((rx ^ ref_v) & ~ignore) == 8'h00);
  endfunction

  assign is_hdlc  = (ENGINE_SELECT == `HAMF_ENG_HDLC);
  assign ppp_on   = is_hdlc && (PPP_VARIANT_SELECT != `HAMF_PPP_OFF);
  assign unmap_on = ppp_on && (PPP_VARIANT_SELECT != `HAMF_PPP_BITSYNC);
  // PPP and transparent behave as address mode 0
  assign mode0_like = ppp_on || (HDLC_SUBMODE_SELECT == `HAMF_SUB_TRANSP) ||
                      ((HDLC_SUBMODE_SELECT == `HAMF_SUB_ADDRMODE) && !ADDRESS_WIDTH_SELECT);

  // Input taken only when no status byte is waiting
  assign RX_READY = fifo_in_ready & ~pend_ff;
  assign beat     = RX_VALID & RX_READY;

  // escape octet swallowed, following octet unmapped
  assign byte_ok  = !(unmap_on && !esc_ff && (RX_DATA == `HAMF_PPP_ESC));
  assign rx_byte  = esc_ff ? (RX_DATA ^ `HAMF_PPP_XOR) : RX_DATA;

  // bit 1 excluded when command/response handling is on
  assign cr_mask  = HIGH_ADDR_MASK |
                    (CMD_RESP_HANDLING_BIT ? (8'h01 << `HAMF_CR_BIT) : 8'h00);

  // high byte against group values and both compare values
  // masks apply to every compare value
  assign hi_a   = addr_hit(rx_byte, HIGH_ADDR_COMPARE_A, cr_mask);
  assign hi_any = hi_a ||
                  addr_hit(rx_byte, HIGH_ADDR_COMPARE_B, cr_mask) ||
                  addr_hit(rx_byte, `HAMF_GROUP_FE, cr_mask) ||
                  addr_hit(rx_byte, `HAMF_GROUP_FC, cr_mask);
  // low byte against both low compare values
  assign lo_a   = addr_hit(rx_byte, LOW_ADDR_COMPARE_A, LOW_ADDR_MASK);
  assign lo_b   = addr_hit(rx_byte, LOW_ADDR_COMPARE_B, LOW_ADDR_MASK);

  // Frame walk: address decision, window check, storage
  always_comb begin
    nxt_state     = state_ff;
    nxt_auto      = auto_ff;
    nxt_cmd       = cmd_ff;
    nxt_vr        = vr_ff;
    nxt_esc       = esc_ff;
    nxt_pend      = pend_ff;
    nxt_pend_stat = pend_stat_ff;
    wr_now        = 1'b0;
    if (pend_ff && fifo_in_ready) begin
      nxt_pend = 1'b0;
    end
    if (beat) begin
      nxt_esc = !byte_ok;
    end
    if (beat && byte_ok) begin
      case (state_ff)
        HAMF_IDLE: begin
          nxt_auto = 1'b0;
          nxt_cmd  = 1'b0;
          if (!is_hdlc) begin
            nxt_state = HAMF_DROP;
          end else if (mode0_like) begin
            // whole frame stored without address check
            wr_now    = 1'b1;
            nxt_state = HAMF_DATA;
          end else if (HDLC_SUBMODE_SELECT == `HAMF_SUB_ADDRMODE) begin
            // first byte checked and left out
            nxt_state = hi_any ? HAMF_DATA : HAMF_DROP;
          end else if (ADDRESS_WIDTH_SELECT) begin
            nxt_state = HAMF_ADDR2;
          end else begin
            nxt_cmd   = lo_a;
            nxt_auto  = lo_a || lo_b;
            nxt_state = (lo_a || lo_b) ? HAMF_CTRL : HAMF_DROP;
          end
        end
        HAMF_ADDR2: begin
          // both bytes must match a pairing
          // only first-high, first-low pair is auto
          nxt_auto  = hi_a_ff && lo_a;
          nxt_state = (hi_any_ff && (lo_a || lo_b)) ? HAMF_CTRL : HAMF_DROP;
        end
        HAMF_CTRL: begin
          // I-frame out of sequence is not accepted
          if (HDLC_SUBMODE_SELECT == `HAMF_SUB_AUTO && auto_ff && !rx_byte[0] &&
              (rx_byte[1] != vr_ff)) begin
            nxt_state = HAMF_DROP;
          end else begin
            if (HDLC_SUBMODE_SELECT == `HAMF_SUB_AUTO && auto_ff && !rx_byte[0]) begin
              nxt_vr = ~vr_ff;
            end
            // control field stored; in auto mode only after the window check above passes
            wr_now    = 1'b1;
            nxt_state = HAMF_DATA;
          end
        end
        HAMF_DATA: begin
          wr_now = 1'b1;
        end
        HAMF_DROP: begin
          wr_now = 1'b0;
        end
        default: nxt_state = HAMF_IDLE;
      endcase
      if (RX_LAST) begin
        // status only for frames that reached storage
        nxt_pend = (nxt_state == HAMF_DATA);
        nxt_pend_stat = {RX_STATUS,
                         (nxt_auto && HDLC_SUBMODE_SELECT == `HAMF_SUB_AUTO), nxt_cmd};
        nxt_state = HAMF_IDLE;
        nxt_esc   = 1'b0;
      end
    end
  end

  // High byte flags captured for the second address byte
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      hi_a_ff   <= 1'b0;
      hi_any_ff <= 1'b0;
    end else if (beat && byte_ok && state_ff == HAMF_IDLE) begin
      hi_a_ff   <= hi_a;
      hi_any_ff <= hi_any;
    end
  end

  // Frame walk registers
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      state_ff     <= HAMF_IDLE;
      auto_ff      <= 1'b0;
      cmd_ff       <= 1'b0;
      vr_ff        <= 1'b0;
      esc_ff       <= 1'b0;
      pend_ff      <= 1'b0;
      pend_stat_ff <= 8'h00;
    end else begin
      state_ff     <= nxt_state;
      auto_ff      <= nxt_auto;
      cmd_ff       <= nxt_cmd;
      vr_ff        <= nxt_vr;
      esc_ff       <= nxt_esc;
      pend_ff      <= nxt_pend;
      pend_stat_ff <= nxt_pend_stat;
    end
  end

  // FIFO write: waiting status byte first, then the current byte
  assign fifo_in = pend_ff ? {1'b1, pend_stat_ff} : {1'b0, rx_byte};

  hamf_fifo #(
    .WIDTH (W),
    .DEPTH (FIFO_DEPTH)
  ) u_rfifo (
    .SYS_CLK   (SYS_CLK),
    .RSTN      (RSTN),
    .IN_DATA   (fifo_in),
    .IN_VALID  (pend_ff | wr_now),
    .IN_READY  (fifo_in_ready),
    .OUT_DATA  (fifo_out),
    .OUT_VALID (RFIFO_VALID),
    .OUT_READY (RFIFO_READY)
  );

  assign RFIFO_DATA      = fifo_out[7:0];
  assign RFIFO_IS_STATUS = fifo_out[8];

  // Mode decode for the serial engines
  always_comb begin
    nxt_mode[0] = is_hdlc;
    nxt_mode[1] = (ENGINE_SELECT == `HAMF_ENG_ASYNC);
    nxt_mode[2] = (ENGINE_SELECT == `HAMF_ENG_BISYNC);
    // transparent runs inside the HDLC engine
    nxt_mode[3] = is_hdlc && !ppp_on && (HDLC_SUBMODE_SELECT == `HAMF_SUB_TRANSP);
    nxt_mode[4] = is_hdlc && !nxt_mode[3] && (PPP_VARIANT_SELECT != `HAMF_PPP_OCTET);
    // mapping for asynchronous and octet PPP
    nxt_mode[5] = unmap_on;
    nxt_mode[6] = ppp_on && (PPP_VARIANT_SELECT == `HAMF_PPP_ASYNC);
    // PPP with the width bit set is not allowed
    nxt_mode[7] = ppp_on && ADDRESS_WIDTH_SELECT;
    // longer abort run for bit synchronous PPP
    nxt_abort = (ppp_on && PPP_VARIANT_SELECT == `HAMF_PPP_BITSYNC) ?
                `HAMF_ABORT_PPP : `HAMF_ABORT_HDLC;
  end

  // Mode decode registers, one per flag
  for (genvar i = 0; i < 8; i++) begin : g_mode
    always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
        mode_ff[i] <= 1'b0;
      end else begin
        mode_ff[i] <= nxt_mode[i];
      end
    end
  end

  // Abort length register
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      abort_ff <= `HAMF_ABORT_HDLC;
    end else begin
      abort_ff <= nxt_abort;
    end
  end

  assign ENGINE_HDLC      = mode_ff[0];
  assign ENGINE_ASYNC     = mode_ff[1];
  assign ENGINE_BISYNC    = mode_ff[2];
  assign MODE_TRANSPARENT = mode_ff[3];
  assign STUFFING_ON      = mode_ff[4];
  assign CHAR_MAP_ON      = mode_ff[5];
  assign ASYNC_CHAR_ON    = mode_ff[6];
  assign CONFIG_ERROR     = mode_ff[7];
  assign ASYNC_CHAR_BITS  = `HAMF_CHAR_BITS;
  assign ABORT_MIN_ONES   = abort_ff;
endmodule

/* hw/hamf_pkg.sv */
// Types shared by the HDLC mode and address filter block
package hamf_pkg;
  typedef enum logic [2:0] {
    HAMF_IDLE  = 3'b000,
    HAMF_ADDR2 = 3'b001,
    HAMF_CTRL  = 3'b011,
    HAMF_DATA  = 3'b010,
    HAMF_DROP  = 3'b110
  } hamf_state_type;
endpackage

/* test/hamf_filter_chk.sv */
// Checker for mode decode and FIFO head of the address filter
module hamf_filter_chk
  import hamf_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic       SYS_CLK,
  input wire logic       RSTN,
  input wire logic [1:0] ENGINE_SELECT,
  input wire logic [1:0] HDLC_SUBMODE_SELECT,
  input wire logic       ADDRESS_WIDTH_SELECT,
  input wire logic [1:0] PPP_VARIANT_SELECT,
  input wire logic [7:0] RFIFO_DATA,
  input wire logic       RFIFO_IS_STATUS,
  input wire logic       RFIFO_VALID,
  input wire logic       RFIFO_READY,
  input wire logic       ENGINE_HDLC,
  input wire logic       ENGINE_ASYNC,
  input wire logic       ENGINE_BISYNC,
  input wire logic       MODE_TRANSPARENT,
  input wire logic       STUFFING_ON,
  input wire logic       CHAR_MAP_ON,
  input wire logic       ASYNC_CHAR_ON,
  input wire logic [3:0] ASYNC_CHAR_BITS,
  input wire logic [3:0] ABORT_MIN_ONES,
  input wire logic       CONFIG_ERROR
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);
  logic [1:0] eng_ff, sub_ff, ppp_ff;
  logic       wid_ff, run_ff;
  // Configuration and reset level seen at the previous edge
  always_ff @(posedge SYS_CLK) begin
    eng_ff <= ENGINE_SELECT;
    sub_ff <= HDLC_SUBMODE_SELECT;
    ppp_ff <= PPP_VARIANT_SELECT;
    wid_ff <= ADDRESS_WIDTH_SELECT;
    run_ff <= RSTN;
  end
  // Out of reset for an edge with the HDLC engine chosen
  sequence s_hdlc;
    run_ff && eng_ff == 2'b00;
  endsequence
  // Head word offered but not taken
  sequence s_head_wait;
    RFIFO_VALID && !RFIFO_READY;
  endsequence
  a_engine_code_map:
    assert property (run_ff |-> ENGINE_HDLC == (eng_ff == 2'b00) &&
      ENGINE_ASYNC == (eng_ff == 2'b11) && ENGINE_BISYNC == (eng_ff == 2'b10))
    else $error("engine decode wrong");
  a_transp_mode_sel:
    assert property (s_hdlc |-> MODE_TRANSPARENT == (sub_ff == 2'b11 && ppp_ff == 2'b00))
    else $error("transparent decode wrong");
  a_stuffing_sel:
    assert property (s_hdlc |->
      STUFFING_ON == (!(sub_ff == 2'b11 && ppp_ff == 2'b00) && ppp_ff != 2'b01))
    else $error("stuffing decode wrong");
  a_char_map_sel:
    assert property (s_hdlc |-> CHAR_MAP_ON == (ppp_ff == 2'b01 || ppp_ff == 2'b10))
    else $error("mapping decode wrong");
  a_async_char_fmt:
    assert property (s_hdlc |-> ASYNC_CHAR_ON == (ppp_ff == 2'b10) && ASYNC_CHAR_BITS == 4'ha)
    else $error("async character wrong");
  a_abort_run_len:
    assert property (s_hdlc |-> ABORT_MIN_ONES == ((ppp_ff == 2'b11) ? 4'hf : 4'h7))
    else $error("abort length wrong");
  a_ppp_width_err:
    assert property (s_hdlc |-> CONFIG_ERROR == (ppp_ff != 2'b00 && wid_ff))
    else $error("config error flag wrong");
  a_head_word_hold:
    assert property (s_head_wait |=> RFIFO_VALID && $stable(RFIFO_DATA) &&
      $stable(RFIFO_IS_STATUS))
    else $error("head word lost");
endmodule

bind hamf_filter hamf_filter_chk #(.FIFO_DEPTH(FIFO_DEPTH)) i_chk (
  .SYS_CLK(SYS_CLK), .RSTN(RSTN), .ENGINE_SELECT(ENGINE_SELECT),
  .HDLC_SUBMODE_SELECT(HDLC_SUBMODE_SELECT), .ADDRESS_WIDTH_SELECT(ADDRESS_WIDTH_SELECT),
  .PPP_VARIANT_SELECT(PPP_VARIANT_SELECT), .RFIFO_DATA(RFIFO_DATA),
  .RFIFO_IS_STATUS(RFIFO_IS_STATUS), .RFIFO_VALID(RFIFO_VALID), .RFIFO_READY(RFIFO_READY),
  .ENGINE_HDLC(ENGINE_HDLC), .ENGINE_ASYNC(ENGINE_ASYNC), .ENGINE_BISYNC(ENGINE_BISYNC),
  .MODE_TRANSPARENT(MODE_TRANSPARENT), .STUFFING_ON(STUFFING_ON),
  .CHAR_MAP_ON(CHAR_MAP_ON), .ASYNC_CHAR_ON(ASYNC_CHAR_ON),
  .ASYNC_CHAR_BITS(ASYNC_CHAR_BITS), .ABORT_MIN_ONES(ABORT_MIN_ONES),
  .CONFIG_ERROR(CONFIG_ERROR));

/* test/hamf_station.sv */
// Remote station model: offers received frame bytes, promptly or slowly
module hamf_station (
  input  wire logic       sys_clk,
  input  wire logic       rx_ready,
  output logic      [7:0] rx_data,
  output logic            rx_valid,
  output logic            rx_last,
  output logic      [5:0] rx_status
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle lines at start
  initial begin
    rx_data   = 8'h00;
    rx_valid  = 1'b0;
    rx_last   = 1'b0;
    rx_status = 6'h00;
  end
  // Send one frame; each byte held until taken, then gap + 1 idle cycles if gap is nonzero or the byte is last
  task automatic send(input logic [7:0] fr[$], input logic [5:0] st, input int gap);
    for (int i = 0; i < fr.size(); i++) begin
      rx_data   <= fr[i];
      rx_status <= st;
      rx_valid  <= 1'b1;
      rx_last   <= (i == fr.size() - 1);
      do @(posedge sys_clk); while (rx_ready !== 1'b1);
      if (gap > 0 || i == fr.size() - 1) begin
        rx_valid  <= 1'b0;
        rx_last   <= 1'b0;
        rx_data   <= ~fr[i]; // Released lines show no stale value
        rx_status <= ~st;
        repeat (gap + 1) @(posedge sys_clk);
      end
    end
  endtask
endmodule

/* test/tb_top.sv */
// Self-checking bench for the HDLC mode and address filter
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [5:0] st_v = 6'h2a;
  logic       sys_clk = 1'b0;
  logic       rstn = 1'b0;
  logic [1:0] eng = 2'b00;
  logic [1:0] sub = 2'b01;
  logic [1:0] ppp = 2'b00;
  logic       wid = 1'b1;
  logic       crb = 1'b0;
  logic [7:0] hm = 8'h00;
  logic [7:0] lm = 8'h00;
  logic       rf_rdy = 1'b0;
  logic       stall = 1'b0;
  logic [1:0] cyc = 2'b00;
  logic [7:0] rx_data, rf_data;
  logic [5:0] rx_status;
  logic       rx_valid, rx_last, rx_ready, rf_st, rf_vld;
  logic [7:0] big[$];
  logic [8:0] exp_q[$], got_q[$];
  int         error_cnt = 0;
  int         n_checks = 0;
  int         gap = 0;

  hamf_filter #(.FIFO_DEPTH(16)) i_dut (
    .SYS_CLK(sys_clk), .RSTN(rstn), .ENGINE_SELECT(eng), .HDLC_SUBMODE_SELECT(sub),
    .ADDRESS_WIDTH_SELECT(wid), .PPP_VARIANT_SELECT(ppp), .HIGH_ADDR_COMPARE_A(8'h10),
    .HIGH_ADDR_COMPARE_B(8'h20), .LOW_ADDR_COMPARE_A(8'h30), .LOW_ADDR_COMPARE_B(8'h40),
    .CMD_RESP_HANDLING_BIT(crb), .HIGH_ADDR_MASK(hm), .LOW_ADDR_MASK(lm),
    .RX_DATA(rx_data), .RX_VALID(rx_valid), .RX_LAST(rx_last), .RX_STATUS(rx_status),
    .RX_READY(rx_ready), .RFIFO_DATA(rf_data), .RFIFO_IS_STATUS(rf_st),
    .RFIFO_VALID(rf_vld), .RFIFO_READY(rf_rdy), .ENGINE_HDLC(), .ENGINE_ASYNC(),
    .ENGINE_BISYNC(), .MODE_TRANSPARENT(), .STUFFING_ON(), .CHAR_MAP_ON(),
    .ASYNC_CHAR_ON(), .ASYNC_CHAR_BITS(), .ABORT_MIN_ONES(), .CONFIG_ERROR());
  hamf_station i_stn (.sys_clk(sys_clk), .rx_ready(rx_ready), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_last(rx_last), .rx_status(rx_status));

  // 200 MHz clock
  always #2.5 sys_clk = ~sys_clk;
  // Memory side: takes FIFO words, stalling one cycle in four
  always @(posedge sys_clk) begin
    cyc <= cyc + 2'b01;
    rf_rdy <= !stall && cyc != 2'b11;
    if (rstn && rf_vld === 1'b1 && rf_rdy) got_q.push_back({rf_st, rf_data});
  end

  task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Send a frame; words from index skip on are stored, skip -1 means dropped
  task automatic fr(input logic [7:0] f[$], input int skip, input logic [1:0] fl = 2'b00);
    if (skip >= 0) begin
      for (int i = skip; i < f.size(); i++) exp_q.push_back({1'b0, f[i]});
      exp_q.push_back({1'b1, st_v, fl});
    end
    i_stn.send(f, st_v, gap);
  endtask
  task automatic cmp_all(input string nm);
    int k;
    k = 0;
    while (got_q.size() < exp_q.size() && k < 400) begin
      @(posedge sys_clk);
      k++;
    end
    repeat (10) @(posedge sys_clk);
    chk({nm, " count"}, 9'(exp_q.size()), 9'(got_q.size()));
    foreach (exp_q[i]) if (i < got_q.size()) chk(nm, exp_q[i], got_q[i]);
    exp_q.delete();
    got_q.delete();
    $display("test %s done, mismatches %0d", nm, error_cnt);
  endtask
  task automatic cfg(input logic [1:0] e, input logic [1:0] s, input logic [1:0] p,
                     input logic w);
    eng <= e;
    sub <= s;
    ppp <= p;
    wid <= w;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    fr('{8'hfe, 8'h40, 8'hc1, 8'hd1}, 2);
    fr('{8'hfc, 8'h30, 8'hc2}, 2);
    fr('{8'h20, 8'h40, 8'hc3, 8'hd3}, 2);
    fr('{8'h10, 8'h31, 8'hc4}, -1);
    fr('{8'h12, 8'h30, 8'hc5}, -1);
    fr('{8'h55}, -1);
    cmp_all("nonauto");
    crb <= 1'b1;
    hm <= 8'h01;
    fr('{8'h12, 8'h30, 8'hc6}, 2);
    fr('{8'h11, 8'h40, 8'hc7}, 2);
    fr('{8'h14, 8'h30, 8'hc8}, -1);
    lm <= 8'h0f;
    fr('{8'h20, 8'h3a, 8'hc9}, 2);
    fr('{8'h20, 8'h55, 8'hca}, -1);
    cmp_all("cr and mask");
    crb <= 1'b0;
    hm <= 8'h00;
    lm <= 8'h00;
    gap = 2;
    cfg(2'b00, 2'b00, 2'b00, 1'b1);
    fr('{8'h10, 8'h30, 8'h00, 8'hd1}, 2, 2'b10);
    fr('{8'h10, 8'h30, 8'h00}, -1);
    fr('{8'h10, 8'h30, 8'h02, 8'hd2}, 2, 2'b10);
    fr('{8'h20, 8'h30, 8'h00}, 2);
    cmp_all("auto16");
    cfg(2'b00, 2'b00, 2'b00, 1'b0);
    fr('{8'h30, 8'h03, 8'hd4}, 1, 2'b11);
    fr('{8'h40, 8'h03}, 1, 2'b10);
    fr('{8'h50, 8'h03}, -1);
    cmp_all("auto8");
    gap = 0;
    cfg(2'b00, 2'b10, 2'b00, 1'b1);
    fr('{8'hfc, 8'ha2, 8'hc8}, 1);
    fr('{8'h55, 8'ha4}, -1);
    cfg(2'b00, 2'b10, 2'b00, 1'b0);
    fr('{8'h55, 8'h66}, 0);
    cfg(2'b00, 2'b11, 2'b00, 1'b1);
    fr('{8'h99, 8'h88}, 0);
    cfg(2'b00, 2'b10, 2'b11, 1'b0);
    fr('{8'ha1, 8'hb2}, 0);
    cmp_all("address modes");
    for (int p = 1; p < 3; p++) begin
      cfg(2'b00, 2'b10, p[1:0], 1'b0);
      exp_q = '{9'h011, 9'h07e, 9'h022, {1'b1, st_v, 2'b00}};
      i_stn.send('{8'h11, 8'h7d, 8'h5e, 8'h22}, st_v, gap);
      cmp_all("ppp unmap");
    end
    cfg(2'b00, 2'b10, 2'b11, 1'b1);
    cfg(2'b11, 2'b01, 2'b00, 1'b1);
    fr('{8'h10, 8'h30, 8'hc9}, -1);
    cfg(2'b10, 2'b01, 2'b00, 1'b1);
    fr('{8'h10, 8'h30, 8'hc9}, -1);
    cmp_all("other engines");
    stall <= 1'b1;
    for (int i = 0; i < 20; i++) big.push_back(8'(i + 1));
    cfg(2'b00, 2'b10, 2'b00, 1'b0);
    fork
      fr(big, 0);
      begin
        repeat (40) @(posedge sys_clk);
        chk("ready when full", 9'h000, {8'h00, rx_ready});
        chk("words held", 9'h000, 9'(got_q.size()));
        stall <= 1'b0;
      end
    join
    cmp_all("fill and drain");
    chk("drained", 9'h000, {8'h00, rf_vld});
    stop_test();
  end
  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    $display("watchdog expired");
    stop_test();
  end
endmodule
